/* File: dul_dout_unlock.sv */
// data-out pin function selector and phase-error unlock detector
// assumes mode bits, read data and count-done come from logic on clk;
// the strobe, shift clock and phase error are asynchronous and are synchronised here
//
// How it works
// - count-end selected: pin high after count
// - a write or read transfer releases count-end indication, unless a count ends as it starts
// - referenced io pin is output: pin open
// - three-bit select sets pin behaviour otherwise
// - strobe high in write modes: pin open
// - strobe high in read: shift read data
// - unlocked when phase error exceeds chosen width
`timescale 1ns/100ps
module dul_dout_unlock
  import dul_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        bus_select,
  input  wire logic        bus_shift_clock,
  input  wire logic        write_mode_one,
  input  wire logic        write_mode_two,
  input  wire logic        read_mode,
  input  wire logic        serial_read_bit,
  input  wire logic        if_count_done,
  input  wire logic        phase_error,
  output logic             dout_o,
  output logic             dout_oe,
  output logic             unlock_o,
  output logic             unlock_oe
);

  // ****************************************************
  // synchronisers
  // ****************************************************
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic       sel_s;
  logic       sck_s;
  logic       perr_s;
  logic       sel_d;
  logic       sck_d;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      sel_d  <= 1'b0;
      sck_d  <= 1'b0;
    end else if (clk_en) begin
      sync_a <= {phase_error, bus_shift_clock, bus_select};
      sync_b <= sync_a;
      sel_d  <= sel_s;
      sck_d  <= sck_s;
    end
  end

  assign sel_s  = sync_b[0];
  assign sck_s  = sync_b[1];
  assign perr_s = sync_b[2];

  wire xfer_start = sel_s && !sel_d;
  wire sck_fall   = sck_d && !sck_s;
  wire wr_mode    = write_mode_one || write_mode_two;

  // ****************************************************
  // ahb-lite slave
  // ****************************************************
  logic [CTRL_W-1:0] ctrl;
  logic              ph_wr;
  logic [7:0]        ph_addr;
  logic              count_end;
  logic              unlocked;

  wire        take     = hsel && hready && htrans[1];
  wire        ctrl_hit = ph_wr && (ph_addr == CTRL_OFFSET);
  wire [31:0] status   = {28'h000_0000, dout_o, dout_oe, unlocked, count_end};
  wire [31:0] rd_mux   = (haddr[7:0] == CTRL_OFFSET && haddr[31:8] == 24'h00_0000) ?
                         {25'h000_0000, ctrl} :
                         (haddr[7:0] == STATUS_OFFSET && haddr[31:8] == 24'h00_0000) ?
                         status : 32'h0000_0000;

  assign hreadyout = clk_en;
  assign hresp     = 1'b0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_wr   <= 1'b0;
      ph_addr <= 8'h00;
      hrdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      ph_wr   <= take && hwrite && (haddr[31:8] == 24'h00_0000);
      ph_addr <= haddr[7:0];
      if (take && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // hsize is accepted as word only; narrower writes still update the word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CTRL_RESET[CTRL_W-1:0];
    end else if (clk_en && ctrl_hit) begin
      ctrl <= hwdata[CTRL_W-1:0];
    end
  end

  wire [2:0] dsel     = ctrl[CTRL_DSEL_LSB +: 3];
  wire [1:0] ul_width = ctrl[CTRL_UL_LSB +: 2];
  wire       io1_out  = ctrl[CTRL_IO1_OUT];
  wire       io2_out  = ctrl[CTRL_IO2_OUT];

  // ****************************************************
  // count-end indication
  // ****************************************************
  // the set wins so a count finishing on a transfer start is not lost
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_end <= 1'b0;
    end else if (clk_en) begin
      if (if_count_done) begin
        count_end <= 1'b1;
      end else if (xfer_start && (wr_mode || read_mode)) begin
        count_end <= 1'b0;
      end
    end
  end

  // ****************************************************
  // unlock detector
  // ****************************************************
  logic [PERR_CNT_W-1:0] perr_cnt;

  wire [PERR_CNT_W-1:0] ul_thr = (ul_width == UL_WIDTH2) ?
                                 PERR_CNT_W'(UL_WIDTH2_CYC) : PERR_CNT_W'(UL_WIDTH3_CYC);
  wire next_unlocked = (ul_width == UL_STOP)   ? 1'b0 :
                       (ul_width == UL_DIRECT) ? perr_s :
                       (perr_s && perr_cnt >= ul_thr);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      perr_cnt <= '0;
    end else if (clk_en) begin
      if (!perr_s) begin
        perr_cnt <= '0;
      end else if (perr_cnt != '1) begin
        perr_cnt <= perr_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      unlocked  <= 1'b0;
      unlock_o  <= 1'b0;
      unlock_oe <= 1'b0;
    end else if (clk_en) begin
      unlocked  <= next_unlocked;
      unlock_o  <= next_unlocked;
      unlock_oe <= (ul_width != UL_STOP);
    end
  end

  // ****************************************************
  // data-out pin
  // ****************************************************
  logic read_bit;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      read_bit <= 1'b0;
    end else if (clk_en && sck_fall) begin
      read_bit <= serial_read_bit;
    end
  end

  // bus phase overrides the select; select then picks the idle function
  wire bus_wr = sel_s && wr_mode;
  wire bus_rd = sel_s && read_mode && !wr_mode;
  wire io_blk = (dsel == DSEL_IO1 && io1_out) || (dsel == DSEL_IO2 && io2_out);
  wire sel_oe = !io_blk && ((dsel == DSEL_UNLOCK && unlocked) ||
                            (dsel == DSEL_COUNT_END && count_end));
  wire next_oe = bus_wr ? 1'b0 :
                 bus_rd ? 1'b1 :
                 io_blk ? 1'b0 :
                 sel_oe;
  wire next_do = bus_rd ? read_bit : 1'b1;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dout_o  <= 1'b0;
      dout_oe <= 1'b0;
    end else if (clk_en) begin
      dout_o  <= next_do;
      dout_oe <= next_oe;
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_write_open: assert property (clk_en && bus_wr |=> !dout_oe)
    else $error("data-out driven during write transfer");

  a_read_drive: assert property (clk_en && bus_rd |=> dout_oe)
    else $error("data-out not driven during read transfer");

  a_read_data: assert property (clk_en && sck_fall && bus_rd ##1 clk_en && bus_rd
                                |=> dout_o == $past(serial_read_bit, 2))
    else $error("read data not shifted on shift clock fall");

  a_count_high: assert property (clk_en && count_end && !sel_s
                                 && dsel == DSEL_COUNT_END |=> dout_oe && dout_o)
    else $error("count end not shown on data-out");

  a_count_clear: assert property (clk_en && xfer_start && read_mode && !if_count_done
                                  |=> !count_end)
    else $error("count end not released by transfer");

  a_count_set: assert property (clk_en && if_count_done |=> count_end)
    else $error("count completion lost");

  a_io_open: assert property (clk_en && !sel_s && dsel == DSEL_IO1 && io1_out
                              |=> !dout_oe)
    else $error("data-out driven while io pin is output");

  a_ul_stop: assert property (clk_en && ul_width == UL_STOP |=> !unlock_oe && !unlocked)
    else $error("unlock output active while stopped");

  a_ul_direct: assert property (clk_en && ul_width == UL_DIRECT
                                |=> unlock_o == $past(perr_s))
    else $error("direct phase error not passed");

  // a frozen cycle would hold a flag taken under an older width, so it is left out
  a_ul_narrow: assert property (clk_en && ul_width == UL_WIDTH2 && unlock_o
                                && $past(ul_width) == UL_WIDTH2 && $past(clk_en)
                                |-> $past(perr_cnt) >= PERR_CNT_W'(UL_WIDTH2_CYC))
    else $error("unlock flagged on short phase error");

  c_read_xfer:  cover property (bus_rd ##1 sck_fall ##[1:20] !sel_s);
  c_count_end:  cover property (if_count_done ##[1:50] xfer_start);
  c_unlock:     cover property (ul_width == UL_WIDTH2 && $rose(unlocked));
  c_write_xfer: cover property (bus_wr && count_end);

endmodule

/* File: dul_pkg.sv */
// constants for the data-out pin selector and unlock detector
// assumes a 10 MHz system clock and a 32-bit AHB-Lite register port
package dul_pkg;

  // ****************************************************
  // clock and timing
  // ****************************************************
  localparam int CLK_PERIOD_NS  = 100;
  localparam int UL_WIDTH2_NS   = 550;
  localparam int UL_WIDTH3_NS   = 1100;
  // least widths round up to whole cycles
  localparam int UL_WIDTH2_CYC  = (UL_WIDTH2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int UL_WIDTH3_CYC  = (UL_WIDTH3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PERR_CNT_W     = 5;

  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0]  CTRL_OFFSET    = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET  = 8'h04;
  localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;

  localparam int CTRL_DSEL_LSB   = 0;
  localparam int CTRL_UL_LSB     = 3;
  localparam int CTRL_IO1_OUT    = 5;
  localparam int CTRL_IO2_OUT    = 6;
  localparam int CTRL_W          = 7;

  localparam int STAT_COUNT_END  = 0;
  localparam int STAT_UNLOCKED   = 1;
  localparam int STAT_DOUT_OE    = 2;
  localparam int STAT_DOUT_LEVEL = 3;

  // ****************************************************
  // data-out function select and unlock width codes
  // ****************************************************
  localparam logic [2:0] DSEL_OPEN      = 3'h0;
  localparam logic [2:0] DSEL_UNLOCK    = 3'h1;
  localparam logic [2:0] DSEL_COUNT_END = 3'h2;
  localparam logic [2:0] DSEL_IO1       = 3'h3;
  localparam logic [2:0] DSEL_IO2       = 3'h4;

  localparam logic [1:0] UL_STOP   = 2'h0;
  localparam logic [1:0] UL_DIRECT = 2'h1;
  localparam logic [1:0] UL_WIDTH2 = 2'h2;

endpackage

/* File: dul_ctrl_model.sv */
// serial bus controller model facing the data-out block
// assumes the bench calls frame() and watches edge_pt to time read data
`timescale 1ns/100ps
module dul_ctrl_model (
  input  wire logic clk,
  output logic      bus_select,
  output logic      bus_shift_clock,
  output logic      write_mode_one,
  output logic      write_mode_two,
  output logic      read_mode,
  output logic      edge_pt
);
  initial begin
    {bus_select, write_mode_one, write_mode_two, read_mode, edge_pt} = 5'h00;
    bus_shift_clock = 1'h1;
  end
  // ********************************
  // frame sequencer
  // ********************************
  // m: 0 write one, 1 write two, 2 read; edge_pt warns one cycle before each fall
  task automatic frame(input int m, input int n);
    int k;
    begin
      write_mode_one <= (m == 0);
      write_mode_two <= (m == 1);
      read_mode      <= (m == 2);
      repeat (2) @(posedge clk);
      bus_select <= 1'h1;
      repeat (4) @(posedge clk);
      for (k = 0; k <= n; k++) begin
        edge_pt <= 1'h1;
        @(posedge clk);
        edge_pt <= 1'h0;
        if (k < n) begin
          // clock stands high outside frames, 800 ns a bit inside
          bus_shift_clock <= 1'h0;
          repeat (4) @(posedge clk);
          bus_shift_clock <= 1'h1;
          repeat (3) @(posedge clk);
        end
      end
      bus_select <= 1'h0;
      // modes held until the synchronised strobe has surely dropped
      repeat (4) @(posedge clk);
      {write_mode_one, write_mode_two, read_mode} <= 3'h0;
    end
  endtask
endmodule

/* File: test_dul_dout_unlock.sv */
// self-checking bench for the data-out selector and unlock detector
// assumes a 10 MHz clock and the serial controller model beside the block
`timescale 1ns/100ps
module test_dul_dout_unlock;
  import dul_pkg::*;
  logic        clk = 1'h0, rstn = 1'h0, hwrite = 1'h0, serial_read_bit = 1'h0, pb;
  logic        if_count_done = 1'h0, phase_error = 1'h0, hreadyout, hresp, clk_en = 1'h1;
  logic        bus_select, bus_shift_clock, write_mode_one, write_mode_two, read_mode;
  logic        dout_o, dout_oe, unlock_o, unlock_oe, edge_pt;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rnd = 32'h0000_000a;
  logic [31:0] exp_q[$], got_q[$];
  string       nm_q[$];
  int          bad_count = 0, samples_checked = 0, c;
  int          ul_w[6] = '{15, 2, 4, 10, 9, 15};
  logic [1:0]  ul_c[6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  logic        ul_h[6] = '{1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1};

  always #50 clk = ~clk;

  dul_dout_unlock i_dut (
    .clk, .rstn, .clk_en, .hsel(1'h1), .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .bus_select, .bus_shift_clock,
    .write_mode_one, .write_mode_two, .read_mode, .serial_read_bit, .if_count_done,
    .phase_error, .dout_o, .dout_oe, .unlock_o, .unlock_oe
  );
  dul_ctrl_model i_ctrl (
    .clk, .bus_select, .bus_shift_clock, .write_mode_one, .write_mode_two, .read_mode, .edge_pt
  );

  // ********************************
  // helpers
  // ********************************
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic note(input string nm, input logic [31:0] e, input logic [31:0] g);
    nm_q.push_back(nm);
    exp_q.push_back(e);
    got_q.push_back(g);
  endtask
  // results are compared away from the driving edge
  always @(negedge clk) begin
    while (got_q.size() > 0) cmp(nm_q.pop_front(), exp_q.pop_front(), got_q.pop_front());
  end
  task automatic wait_for(input logic pt);
    int n;
    for (n = 0; n < 100; n++) begin
      @(posedge clk);
      if ((pt ? edge_pt : hreadyout) === 1'h1) return;
    end
    bad_count++;
    report_and_stop();
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    htrans <= 2'h2;
    haddr  <= {24'h00_0000, a};
    hwrite <= wr;
    wait_for(1'h0);
    htrans <= 2'h0;
    hwdata <= d;
    wait_for(1'h0);
    r = hrdata;
    note("response", 32'h0000_0000, 32'(hresp));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'h1, a, d, r);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'h0, a, 32'h0000_0000, r);
    note(nm, e, r);
  endtask
  task automatic pulse_count();
    if_count_done <= 1'h1;
    @(posedge clk);
    if_count_done <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic serial(input int m, input int n);
    int k;
    fork
      i_ctrl.frame(m, n);
      for (k = 0; k <= n; k++) begin
        wait_for(1'h1);
        if (k > 0 && m == 2) note("read bit", {30'h0000_0000, 1'h1, pb},
                                  32'({dout_oe, dout_o}));
        if (k > 0 && m != 2) note("write oe", 32'h0000_0000, 32'(dout_oe));
        rnd = xs(rnd);
        pb = rnd[0];
        serial_read_bit <= rnd[0];
      end
    join
  endtask
  task automatic unlock_case(input logic [1:0] ul, input int w, input logic hit);
    int n;
    logic [2:0] seen;
    wr(CTRL_OFFSET, 32'(DSEL_UNLOCK) | (32'(ul) << CTRL_UL_LSB));
    seen = 3'h0;
    phase_error <= 1'h1;
    for (n = 0; n < w + 8; n++) begin
      @(posedge clk);
      if (n == w - 1) phase_error <= 1'h0;
      seen = seen | {unlock_oe, unlock_o, dout_oe & dout_o};
    end
    cmp("unlock", (ul == 2'h0) ? 32'h0000_0000 : 32'({1'h1, hit, hit}),
        32'(seen));
  endtask

  // ********************************
  // main sequence
  // ********************************
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    @(posedge clk);
    rd("ctrl reset", CTRL_OFFSET, CTRL_RESET);
    rnd = xs(rnd);
    wr(CTRL_OFFSET, rnd & 32'h0000_007f);
    rd("ctrl rw", CTRL_OFFSET, rnd & 32'h0000_007f);
    wr(8'h08, 32'hffff_ffff);
    rd("unmapped", 8'h08, 32'h0000_0000);
    wr(STATUS_OFFSET, 32'hffff_ffff);
    rd("ctrl kept", CTRL_OFFSET, rnd & 32'h0000_007f);
    $display("test registers done");
    wr(CTRL_OFFSET, 32'(DSEL_COUNT_END));
    // a count finishing while the enable is low must be lost
    clk_en <= 1'h0;
    pulse_count();
    note("frozen ready", 32'h0000_0000, 32'(hreadyout));
    clk_en <= 1'h1;
    repeat (2) @(posedge clk);
    note("frozen count", 32'h0000_0000, 32'(dout_oe));
    pulse_count();
    rd("status", STATUS_OFFSET, 32'h0000_000d);
    // every select code, with and without the io pins set as outputs
    for (c = 0; c < 32; c++) begin
      wr(CTRL_OFFSET, 32'(c[2:0]) | (32'(c[4:3]) << CTRL_IO1_OUT));
      repeat (2) @(posedge clk);
      note("select oe", 32'(c[2:0] == DSEL_COUNT_END), 32'(dout_oe));
    end
    $display("test select codes done");
    wr(CTRL_OFFSET, 32'(DSEL_COUNT_END));
    for (c = 0; c < 3; c++) begin
      pulse_count();
      note("count oe", 32'h0000_0001, 32'(dout_oe));
      serial(c, (c == 2) ? 16 : 4);
      repeat (4) @(posedge clk);
      note("released", 32'h0000_0000, 32'(dout_oe));
    end
    $display("test serial frames done");
    for (c = 0; c < 6; c++) unlock_case(ul_c[c], ul_w[c], ul_h[c]);
    $display("test unlock widths done");
    repeat (2) @(posedge clk);
    report_and_stop();
  end
endmodule
